// file: dv/clock_select_and_startup_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_select_and_startup_reset_tb;
   logic mclk_i = 1'b0, srst_i = 1'b1, ext_rst_i = 1'b1, wake_i = 1'b0;
   logic [6:0] fuse = 7'h22;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rd;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [1:0] rs;
   wire logic int_rst, core_en, per_en, pm_en, asy_en, conv_en, det_en, wdt_t, osc_t, asy_t;
   wire logic awready, wready, bvalid, arready, rvalid;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int n_errors = 0, tests_run = 0;
   // Shortened counts keep the run brief; expectations follow them
   localparam logic [6:0] FU[8] = '{7'h22, 7'h40, 7'h53, 7'h44, 7'h5F, 7'h66, 7'h71, 7'h4E};
   localparam int TN[8] = '{16, 0, 8, 0, 0, 0, 16, 8};
   localparam int TM[8] = '{20, 20, 20, 38, 34, 1038, 20, 272};
   initial forever #5 mclk_i = !mclk_i;
   cssr_osc_model osc_u (.mclk_i(mclk_i), .wdt_tick_o(wdt_t), .osc_tick_o(osc_t),
      .asy_tick_o(asy_t));
   cssr_top #(.TOUT_SHORT(16'h0008), .TOUT_LONG(16'h0010), .SU_16K(16'h0014),
      .SU_32K(16'h0018)) dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .ext_rst_i(ext_rst_i),
      .fuse_bits_i(fuse), .wdt_tick_i(wdt_t), .osc_tick_i(osc_t), .asy_tick_i(asy_t),
      .wake_i(wake_i), .int_rst_o(int_rst), .core_clock_en_o(core_en),
      .peripheral_clock_en_o(per_en), .program_memory_clock_en_o(pm_en),
      .async_timer_clock_en_o(asy_en), .converter_clock_en_o(conv_en),
      .async_detect_en_o(det_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task results;
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   // Ready is looked at mid-cycle, the item moves at the next rising edge
   task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge mclk_i);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do @(negedge mclk_i); while (!(awready && wready));
      @(posedge mclk_i);
      awv <= 1'b0;
      wv <= 1'b0;
      do @(negedge mclk_i); while (!bvalid);
      @(posedge mclk_i);
      r = bresp;
      bready <= 1'b0;
   endtask : axw
   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk_i);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do @(negedge mclk_i); while (!arready);
      @(posedge mclk_i);
      arv <= 1'b0;
      do @(negedge mclk_i); while (!rvalid);
      @(posedge mclk_i);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr
   // Reset release, n watchdog ticks, then m source ticks before running
   task start(input logic [6:0] f, input int n, input int m);
      @(posedge mclk_i);
      fuse <= f;
      ext_rst_i <= 1'b1;
      @(posedge mclk_i);
      ext_rst_i <= 1'b0;
      if (n > 0) begin
         osc_u.pulse(1, n - 1);
         osc_u.pulse(0, m);
         @(negedge mclk_i);
         chk(int_rst, 1'b1);
         osc_u.pulse(1, 1);
      end
      osc_u.pulse(0, m - 1);
      @(negedge mclk_i);
      chk(int_rst, 1'b1);
      osc_u.pulse(0, 1);
      @(negedge mclk_i);
      chk(int_rst, 1'b0);
      axr(8'h08, rd, rs);
      chk(rd, {25'h0, f});
   endtask : start
   // Enables counted over sixteen source ticks
   task gate(input int ec, input int ep, input int ev, input bit ea);
      int c, p, v, a;
      c = 0;
      p = 0;
      v = 0;
      a = 0;
      fork
         osc_u.pulse(0, 16);
         repeat (34) begin
            @(negedge mclk_i);
            c += core_en & pm_en;
            p += per_en;
            v += conv_en;
            a += asy_en;
         end
      join
      chk(c, ec);
      chk(p, ep);
      chk(v, ev);
      chk(a != 0, ea);
   endtask : gate
   // Sleep with a mode, judge the gating, then wake
   task slp(input logic [1:0] md, input int ep, input int ev, input bit ea, input bit dp);
      axw(8'h00, {27'h000_0000, 1'b1, 2'h0, md}, rs);
      chk(rs, 2'h0);
      gate(0, ep, ev, ea);
      chk(det_en, ep == 0);
      @(posedge mclk_i);
      wake_i <= 1'b1;
      @(posedge mclk_i);
      wake_i <= 1'b0;
      @(negedge mclk_i);
      chk(int_rst, dp);
      if (dp) begin
         osc_u.pulse(0, 6);
         @(negedge mclk_i);
         chk(int_rst, 1'b0);
      end
   endtask : slp
   initial begin
      repeat (8) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      ext_rst_i <= 1'b0;
      // Restart in mid time-out must begin counting again
      osc_u.pulse(1, 10);
      for (int i = 0; i < 8; i++) begin
         start(FU[i], TN[i], TM[i]);
         if (i < 2) gate(i ? 16 : 2, i ? 16 : 2, i ? 16 : 2, 1'b1);
      end
      start(7'h40, 0, 20);
      slp(2'h2, 0, 0, 1'b0, 1'b1);
      slp(2'h3, 0, 0, 1'b1, 1'b1);
      slp(2'h0, 16, 16, 1'b1, 1'b0);
      slp(2'h1, 0, 16, 1'b1, 1'b0);
      axr(8'h04, rd, rs);
      chk(rd, 32'h0000_0003);
      axr(8'h10, rd, rs);
      chk(rs, 2'h2);
      axw(8'h08, 32'h0000_0000, rs);
      chk(rs, 2'h2);
      results();
   end
   initial begin
      #300000;
      n_errors++;
      results();
   end
endmodule : clock_select_and_startup_reset_tb
`default_nettype wire

// file: dv/cssr_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Oscillator sources; main and watchdog ticks stay low outside requested bursts
module cssr_osc_model (
   input wire logic mclk_i, // Clock
   output logic wdt_tick_o, // Watchdog tick
   output logic osc_tick_o, // Source tick
   output logic asy_tick_o // Async tick
);
   logic [1:0] asy_cnt = 2'h0;
   initial begin
      wdt_tick_o = 1'b0;
      osc_tick_o = 1'b0;
      asy_tick_o = 1'b0;
   end
   // Async crystal runs free so the timer keeps counting in sleep modes other than power-down
   always @(posedge mclk_i) begin
      asy_cnt <= asy_cnt + 2'h1;
      asy_tick_o <= (asy_cnt == 2'h3);
   end
   // A gap between ticks, as a real slow oscillator would leave
   task automatic pulse(input bit w, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_i);
         wdt_tick_o <= w;
         osc_tick_o <= !w;
         @(posedge mclk_i);
         wdt_tick_o <= 1'b0;
         osc_tick_o <= 1'b0;
      end
   endtask : pulse
endmodule : cssr_osc_model
`default_nettype wire

// file: verilog/cssr_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// Fuse fields in, decoded counts out
interface cssr_cfg_if;
   logic [3:0] src_sel;
   logic [1:0] su_len;
   logic [15:0] tout_cycles;
   logic [15:0] su_cycles;
   cssr_pkg::cssr_src_type src;
   modport decoder(input src_sel, su_len, output tout_cycles, su_cycles, src);
   modport user(output src_sel, su_len, input tout_cycles, su_cycles, src);
endinterface : cssr_cfg_if
`default_nettype wire

// file: verilog/cssr_clk_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssr_defines.svh"
module cssr_clk_gate (
   input wire logic mclk_i, // System clock
   input wire logic srst_i, // Sync reset
   input wire logic running_i, // Core released and awake
   input wire logic sleeping_i, // In a sleep mode
   input wire cssr_pkg::cssr_sleep_type mode_i, // Active sleep mode
   input wire logic div8_i, // Divide-by-eight fuse programmed
   input wire logic osc_tick_i, // Selected source edge
   input wire logic asy_tick_i, // Async timer source edge
   output logic core_clock_en_o, // Core domain enable
   output logic peripheral_clock_en_o, // Peripheral domain enable
   output logic program_memory_clock_en_o, // Program memory enable
   output logic async_timer_clock_en_o, // Async timer enable
   output logic converter_clock_en_o, // Converter enable
   output logic async_detect_en_o // Async wake detectors armed
);
   logic [2:0] div_reg;
   logic [2:0] div_next;

   // Prescaler advances only on source edges
   assign div_next = (div_reg == `CSSR_DIV_LAST) ? 3'h0 : div_reg + 3'h1;
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         div_reg <= 3'h0;
      end else if (osc_tick_i) begin
         div_reg <= div_next;
      end
   end

   // Divided tick lands on the wrap so the first edge after reset is delayed
   wire sys_tick = osc_tick_i & (~div8_i | (div_reg == `CSSR_DIV_LAST));
   wire core_on = running_i;
   wire io_on = running_i | (sleeping_i & (mode_i == cssr_pkg::SLP_IDLE));
   wire adc_on = io_on | (sleeping_i & (mode_i == cssr_pkg::SLP_ADCNR));
   wire asy_on = ~srst_i & ~(sleeping_i & (mode_i == cssr_pkg::SLP_PDOWN));

   assign core_clock_en_o = core_on & sys_tick;
   assign program_memory_clock_en_o = core_on & sys_tick;
   assign peripheral_clock_en_o = io_on & sys_tick;
   assign converter_clock_en_o = adc_on & sys_tick;
   assign async_timer_clock_en_o = asy_on & asy_tick_i;
   // Peripheral clock off: async detectors must carry wake-up
   assign async_detect_en_o = ~io_on;

   flash_core_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      program_memory_clock_en_o == core_clock_en_o)
      else $error("program memory clock not tracking core clock");
   sequence s_eight_ticks;
      (osc_tick_i && div8_i && div_reg == `CSSR_DIV_LAST);
   endsequence
   div_wrap_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      s_eight_ticks |-> (core_clock_en_o == running_i))
      else $error("core enable missing on the eighth source edge");
   div_eight_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      (osc_tick_i && div8_i && div_reg != `CSSR_DIV_LAST) |-> !core_clock_en_o)
      else $error("core enable on a non-eighth source edge");
   undiv_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      (running_i && !div8_i) |-> (core_clock_en_o == osc_tick_i))
      else $error("undivided core enable does not follow source");
   core_sleep_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !running_i |-> !core_clock_en_o && !program_memory_clock_en_o)
      else $error("core clock enabled while not running");
   adc_quiet_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      (sleeping_i && mode_i == cssr_pkg::SLP_ADCNR && osc_tick_i && !div8_i)
      |-> converter_clock_en_o && !peripheral_clock_en_o)
      else $error("converter domain wrong in noise reduction");
   asy_sleep_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      (sleeping_i && mode_i == cssr_pkg::SLP_PSAVE) |-> (async_timer_clock_en_o == asy_tick_i))
      else $error("async timer halted in power save");
endmodule : cssr_clk_gate
`default_nettype wire

// file: verilog/cssr_defines.svh
`ifndef CSSR_DEFINES_SVH
`define CSSR_DEFINES_SVH
// Register byte offsets
`define CSSR_CTRL_OFS 8'h00
`define CSSR_STATUS_OFS 8'h04
`define CSSR_FUSE_OFS 8'h08
`define CSSR_COUNT_OFS 8'h0C
// Control fields
`define CSSR_CTRL_MODE_LSB 0
`define CSSR_CTRL_GO_BIT 4
`define CSSR_CTRL_RST 2'h0
// Latched fuse layout: {divide, startup[1:0], select[3:0]}
`define CSSR_FUSE_SEL_LSB 0
`define CSSR_FUSE_SUT_LSB 4
`define CSSR_FUSE_DIV_BIT 6
`define CSSR_FUSE_DEFAULT 7'h22
// Source select codes, stored polarity
`define CSSR_SEL_EXT 4'h0
`define CSSR_SEL_RSVD 4'h1
`define CSSR_SEL_RC_CAL 4'h2
`define CSSR_SEL_RC_128K 4'h3
// Cycle counts
`define CSSR_TOUT_NONE 16'h0000
`define CSSR_TOUT_SHORT 16'h1000
`define CSSR_TOUT_LONG 16'h2000
`define CSSR_SU_EXT 16'h0006
`define CSSR_SU_258 16'h0102
`define CSSR_SU_1K 16'h0400
`define CSSR_SU_16K 16'h4000
`define CSSR_SU_32K 16'h8000
`define CSSR_SU_RESET_EXTRA 16'h000E
`define CSSR_DIV_LAST 3'h7
// Bus responses
`define CSSR_RESP_OKAY 2'h0
`define CSSR_RESP_SLVERR 2'h2
`endif

// file: verilog/cssr_fuse_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssr_defines.svh"
module cssr_fuse_decode #(
   parameter logic [15:0] TOUT_SHORT = `CSSR_TOUT_SHORT,
   parameter logic [15:0] TOUT_LONG = `CSSR_TOUT_LONG,
   parameter logic [15:0] SU_16K = `CSSR_SU_16K,
   parameter logic [15:0] SU_32K = `CSSR_SU_32K
) (
   cssr_cfg_if.decoder cfg // Fuse fields and decoded counts
);
   // Source class from the select code
   wire is_lp = cfg.src_sel[3];
   wire is_fs = (cfg.src_sel[3:1] == 3'h3);
   wire is_lf = (cfg.src_sel[3:1] == 3'h2);
   wire is_xtal = is_lp | is_fs;
   wire [2:0] xtal_idx = {cfg.src_sel[0], cfg.su_len};

   assign cfg.src = is_lp ? cssr_pkg::SRC_XTAL_LP :
      is_fs ? cssr_pkg::SRC_XTAL_FS :
      is_lf ? cssr_pkg::SRC_XTAL_LF :
      (cfg.src_sel == `CSSR_SEL_RC_128K) ? cssr_pkg::SRC_RC_128K :
      (cfg.src_sel == `CSSR_SEL_RC_CAL) ? cssr_pkg::SRC_RC_CAL :
      (cfg.src_sel == `CSSR_SEL_RSVD) ? cssr_pkg::SRC_RSVD :
      cssr_pkg::SRC_EXT;

   // Crystals: low select bit plus startup field pick both counts
   wire [15:0] xtal_su = (xtal_idx < 3'h2) ? `CSSR_SU_258 :
      (xtal_idx < 3'h5) ? `CSSR_SU_1K : SU_16K;
   wire [15:0] xtal_tout = (xtal_idx == 3'h2 || xtal_idx == 3'h5) ? `CSSR_TOUT_NONE :
      (xtal_idx == 3'h1 || xtal_idx == 3'h4 || xtal_idx == 3'h7) ? TOUT_LONG :
      TOUT_SHORT;
   // Other sources: startup field alone picks the time-out
   wire [15:0] gen_tout = (cfg.su_len == 2'h0) ? `CSSR_TOUT_NONE :
      (cfg.su_len == 2'h1) ? TOUT_SHORT : TOUT_LONG;

   assign cfg.tout_cycles = is_xtal ? xtal_tout : gen_tout;
   assign cfg.su_cycles = is_xtal ? xtal_su :
      is_lf ? SU_32K : `CSSR_SU_EXT;
endmodule : cssr_fuse_decode
`default_nettype wire

// file: verilog/cssr_pkg.sv
package cssr_pkg;
   typedef enum logic [2:0] {
      ST_HOLD, ST_TOUT, ST_OSC, ST_RUN, ST_SLEEP
   } cssr_state_type;
   typedef enum logic [1:0] {
      SLP_IDLE, SLP_ADCNR, SLP_PDOWN, SLP_PSAVE
   } cssr_sleep_type;
   typedef enum logic [2:0] {
      SRC_EXT, SRC_RSVD, SRC_RC_CAL, SRC_RC_128K, SRC_XTAL_LF, SRC_XTAL_FS, SRC_XTAL_LP
   } cssr_src_type;
endpackage : cssr_pkg

// file: verilog/cssr_top.sv
// Functional notes
// - Four-bit select code picks crystal, low-frequency crystal, RC or external source.
// - Fuse bits are inverted: stored one unprogrammed, stored zero programmed.
// - Factory default is calibrated RC, divide-by-eight, startup field 10, max time-out.
// - After other resets release, internal reset holds for an extra time-out.
// - Time-out counts watchdog oscillator cycles, length chosen by fuse fields.
// - Time-out lengths are 0, 4096 or 8192 watchdog cycles.
// - Counter of selected-oscillator cycles holds reset until the count elapses.
// - Oscillator start-up count ranges from 6 (external) to 32K (low-frequency crystal).
// - Start from reset runs time-out then oscillator count, in sequence.
// - Wake from power-save or power-down skips time-out, runs oscillator count only.
// - Clocks of unused domains are gated according to the sleep mode.
// - Gating the core clock halts all core operation.
// - Some interrupt, serial start and two-wire address detection run asynchronously.
// - Program memory clock runs together with the core clock.
// - Async timer clock is independent and keeps running in every sleep mode except power-down.
// - Converter clock stays on in noise reduction sleep while core and peripheral clocks halt.
// - For crystals, low select bit and startup field choose 258, 1K or 16K.
`timescale 1ns/1ps
`default_nettype none
`include "cssr_defines.svh"
module cssr_top #(
   parameter logic [15:0] TOUT_SHORT = `CSSR_TOUT_SHORT, // Short time-out, watchdog cycles
   parameter logic [15:0] TOUT_LONG = `CSSR_TOUT_LONG, // Long time-out, watchdog cycles
   parameter logic [15:0] SU_16K = `CSSR_SU_16K, // Crystal start-up, source cycles
   parameter logic [15:0] SU_32K = `CSSR_SU_32K // Low-freq crystal start-up
) (
   input wire logic mclk_i, // 100 MHz clock
   input wire logic srst_i, // Sync reset, active high
   input wire logic ext_rst_i, // Other reset sources, active high
   input wire logic [6:0] fuse_bits_i, // Stored fuse bits {div, sut, sel}
   input wire logic wdt_tick_i, // Watchdog oscillator edge
   input wire logic osc_tick_i, // Selected oscillator edge
   input wire logic asy_tick_i, // Async timer source edge
   input wire logic wake_i, // Wake-up event from async logic
   output logic int_rst_o, // Internal reset, active high
   output logic core_clock_en_o, // Core domain enable
   output logic peripheral_clock_en_o, // Peripheral domain enable
   output logic program_memory_clock_en_o, // Program memory enable
   output logic async_timer_clock_en_o, // Async timer enable
   output logic converter_clock_en_o, // Converter enable
   output logic async_detect_en_o, // Async detectors armed
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready // Read ready
);
   cssr_pkg::cssr_state_type state_reg;
   cssr_pkg::cssr_state_type state_next;
   cssr_pkg::cssr_sleep_type mode_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [6:0] fuse_reg;
   logic from_reset_reg;
   logic from_reset_next;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;

   cssr_cfg_if cfg ();

   // Fuse fields go to the decoder in stored polarity; codes are written that way
   assign cfg.src_sel = fuse_reg[`CSSR_FUSE_SEL_LSB +: 4];
   assign cfg.su_len = fuse_reg[`CSSR_FUSE_SUT_LSB +: 2];
   wire div8_on = ~fuse_reg[`CSSR_FUSE_DIV_BIT];

   cssr_fuse_decode #(
      .TOUT_SHORT(TOUT_SHORT),
      .TOUT_LONG(TOUT_LONG),
      .SU_16K(SU_16K),
      .SU_32K(SU_32K)
   ) u_decode (
      .cfg(cfg)
   );

   // Fuse image defaults to the factory setting until the straps are read;
   // also latched while other resets are held, so the release decision sees fresh straps
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         fuse_reg <= `CSSR_FUSE_DEFAULT;
      end else if (ext_rst_i || state_reg == cssr_pkg::ST_HOLD) begin
         fuse_reg <= fuse_bits_i;
      end
   end

   // Oscillator target: reset path adds the fixed settle cycles
   wire [15:0] osc_target = from_reset_reg ? (cfg.su_cycles + `CSSR_SU_RESET_EXTRA) :
      cfg.su_cycles;
   wire tout_last = wdt_tick_i && (cnt_reg == (cfg.tout_cycles - 16'h0001));
   wire osc_last = osc_tick_i && (cnt_reg == (osc_target - 16'h0001));
   wire deep_mode = (mode_reg == cssr_pkg::SLP_PDOWN) || (mode_reg == cssr_pkg::SLP_PSAVE);

   // Bus write decode
   wire wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   wire wr_ctrl = wr_take && (s_axi_awaddr == `CSSR_CTRL_OFS) && s_axi_wstrb[0];
   wire wr_hit = (s_axi_awaddr == `CSSR_CTRL_OFS);
   wire sleep_go = wr_ctrl && s_axi_wdata[`CSSR_CTRL_GO_BIT];

   // Start-up and sleep sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      from_reset_next = from_reset_reg;
      case (state_reg)
         cssr_pkg::ST_HOLD: begin
            cnt_next = 16'h0000;
            from_reset_next = 1'b1;
            if (!ext_rst_i) begin
               state_next = (cfg.tout_cycles == `CSSR_TOUT_NONE) ?
                  cssr_pkg::ST_OSC : cssr_pkg::ST_TOUT;
            end
         end
         cssr_pkg::ST_TOUT: begin
            if (tout_last) begin
               state_next = cssr_pkg::ST_OSC;
               cnt_next = 16'h0000;
            end else if (wdt_tick_i) begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end
         cssr_pkg::ST_OSC: begin
            if (osc_last) begin
               state_next = cssr_pkg::ST_RUN;
               cnt_next = 16'h0000;
            end else if (osc_tick_i) begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end
         cssr_pkg::ST_RUN: begin
            if (sleep_go) begin
               state_next = cssr_pkg::ST_SLEEP;
            end
         end
         cssr_pkg::ST_SLEEP: begin
            if (wake_i) begin
               from_reset_next = 1'b0;
               cnt_next = 16'h0000;
               // Oscillator kept running in the light modes, no count needed
               state_next = deep_mode ? cssr_pkg::ST_OSC : cssr_pkg::ST_RUN;
            end
         end
         default: begin
            state_next = cssr_pkg::ST_HOLD;
         end
      endcase
      // Any fresh reset throws both counts away
      if (ext_rst_i) begin
         state_next = cssr_pkg::ST_HOLD;
         cnt_next = 16'h0000;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state_reg <= cssr_pkg::ST_HOLD;
         cnt_reg <= 16'h0000;
         from_reset_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         from_reset_reg <= from_reset_next;
      end
   end

   // Reset stays on through time-out and oscillator count
   assign int_rst_o = (state_reg == cssr_pkg::ST_HOLD) || (state_reg == cssr_pkg::ST_TOUT) ||
      (state_reg == cssr_pkg::ST_OSC);

   // Mode can only change while awake, so sleep gating stays stable
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         mode_reg <= cssr_pkg::cssr_sleep_type'(`CSSR_CTRL_RST);
      end else if (wr_ctrl && state_reg == cssr_pkg::ST_RUN) begin
         mode_reg <= cssr_pkg::cssr_sleep_type'(s_axi_wdata[`CSSR_CTRL_MODE_LSB +: 2]);
      end
   end

   cssr_clk_gate u_gate (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .running_i(state_reg == cssr_pkg::ST_RUN),
      .sleeping_i(state_reg == cssr_pkg::ST_SLEEP),
      .mode_i(mode_reg),
      .div8_i(div8_on),
      .osc_tick_i(osc_tick_i),
      .asy_tick_i(asy_tick_i),
      .core_clock_en_o(core_clock_en_o),
      .peripheral_clock_en_o(peripheral_clock_en_o),
      .program_memory_clock_en_o(program_memory_clock_en_o),
      .async_timer_clock_en_o(async_timer_clock_en_o),
      .converter_clock_en_o(converter_clock_en_o),
      .async_detect_en_o(async_detect_en_o)
   );

   // Write channel: address and data taken together, one response at a time
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `CSSR_RESP_OKAY;
      end else if (wr_take) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? `CSSR_RESP_OKAY : `CSSR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read decode: status, fuse image and live count are read-only
   wire [31:0] status_word = {20'h0_0000, 1'b0, cfg.src, 3'h0, int_rst_o, 1'b0, state_reg};
   wire rd_take = s_axi_arvalid && !rvalid_reg;
   wire rd_ctrl = (s_axi_araddr == `CSSR_CTRL_OFS);
   wire rd_stat = (s_axi_araddr == `CSSR_STATUS_OFS);
   wire rd_fuse = (s_axi_araddr == `CSSR_FUSE_OFS);
   wire rd_cnt = (s_axi_araddr == `CSSR_COUNT_OFS);
   wire rd_hit = rd_ctrl | rd_stat | rd_fuse | rd_cnt;
   wire [31:0] rd_word = rd_ctrl ? {30'h0000_0000, mode_reg} :
      rd_stat ? status_word :
      rd_fuse ? {25'h000_0000, fuse_reg} :
      rd_cnt ? {16'h0000, cnt_reg} : 32'h0000_0000;
   assign s_axi_arready = rd_take;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `CSSR_RESP_OKAY;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_hit ? `CSSR_RESP_OKAY : `CSSR_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Checks on the start-up sequence
   sequence s_released;
      (state_reg == cssr_pkg::ST_HOLD) && !ext_rst_i;
   endsequence
   sequence s_tout_end;
      (state_reg == cssr_pkg::ST_TOUT) && tout_last && !ext_rst_i;
   endsequence
   restart_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ext_rst_i |=> (state_reg == cssr_pkg::ST_HOLD) && int_rst_o && cnt_reg == 16'h0000)
      else $error("reset did not restart the sequence");
   tout_start_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      s_released |=> from_reset_reg && int_rst_o &&
      ((state_reg == cssr_pkg::ST_TOUT) == ($past(cfg.tout_cycles) != 16'h0000)))
      else $error("time-out not entered after reset release");
   tout_to_osc_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      s_tout_end |=> (state_reg == cssr_pkg::ST_OSC) && cnt_reg == 16'h0000 && int_rst_o)
      else $error("time-out end did not start oscillator count");
   tout_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ((state_reg == cssr_pkg::ST_TOUT) && !wdt_tick_i && !ext_rst_i) |=>
      (state_reg == cssr_pkg::ST_TOUT) && $stable(cnt_reg))
      else $error("time-out advanced without watchdog edge");
   osc_release_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ((state_reg == cssr_pkg::ST_OSC) && osc_last && !ext_rst_i) |=>
      !int_rst_o ##1 (state_reg != cssr_pkg::ST_OSC))
      else $error("reset not released after start-up count");
   osc_reset_len_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ((state_reg == cssr_pkg::ST_OSC) && from_reset_reg) |->
      osc_target == cfg.su_cycles + `CSSR_SU_RESET_EXTRA)
      else $error("reset path start-up target wrong");
   wake_deep_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ((state_reg == cssr_pkg::ST_SLEEP) && wake_i && deep_mode && !ext_rst_i) |=>
      (state_reg == cssr_pkg::ST_OSC) && !from_reset_reg)
      else $error("deep wake did not skip time-out");
   default_fuse_a: assert property (@(posedge mclk_i)
      srst_i |=> fuse_reg == `CSSR_FUSE_DEFAULT && cfg.src == cssr_pkg::SRC_RC_CAL)
      else $error("factory default not selected at reset");
endmodule : cssr_top
`default_nettype wire
